// ### hdl/psc_pkg.sv
package psc_pkg;

  // array geometry
  localparam int ADDR_W   = 17;
  localparam int DATA_W   = 32;
  localparam int LANES    = 4;
  localparam int BYTE_W   = 8;
  localparam int LANE_W   = BYTE_W + 1;
  localparam int WORD_W   = LANES * LANE_W;
  localparam int DEPTH    = 1 << ADDR_W;
  localparam int BURST_W  = 2;
  localparam int HI_W     = ADDR_W - BURST_W;

  // byte-lane select value meaning no lane is chosen
  localparam logic [LANES-1:0] LANES_NONE = 4'hF;
  localparam logic [LANES-1:0] LANES_OFF  = 4'h0;

  // sleep entry and exit time in clock cycles
  localparam int SLEEP_CYCLES = 2;
  localparam int SLEEP_CNT_W  = 2;
  localparam logic [SLEEP_CNT_W-1:0] SLEEP_LAST = 2'(SLEEP_CYCLES - 1);

  // reset values
  localparam logic [BURST_W-1:0] BEAT_RESET = 2'h0;
  localparam logic [ADDR_W-1:0]  ADDR_RESET = 17'h00000;

  // kind of access held by a pipeline stage or the burst
  typedef enum logic [1:0] {
    PSC_OP_NONE  = 2'b00,
    PSC_OP_READ  = 2'b01,
    PSC_OP_WRITE = 2'b11
  } psc_op_type;

  // sleep sequencing, gray coded along awake-enter-asleep-wake
  typedef enum logic [1:0] {
    PSC_SLP_AWAKE  = 2'b00,
    PSC_SLP_ENTER  = 2'b01,
    PSC_SLP_ASLEEP = 2'b11,
    PSC_SLP_WAKE   = 2'b10
  } psc_sleep_type;

endpackage : psc_pkg

// ### hdl/psc_array.sv
`timescale 1ns/10ps

module psc_array
  import psc_pkg::*;
(
  // clock
  input  wire logic                          clk_in,
  // read port
  input  wire logic                          rd_en_in,
  input  wire logic [psc_pkg::ADDR_W-1:0]    rd_addr_in,
  output logic      [psc_pkg::WORD_W-1:0]    rd_data_out,
  // write port
  input  wire logic [psc_pkg::LANES-1:0]     wr_lanes_in,
  input  wire logic [psc_pkg::ADDR_W-1:0]    wr_addr_in,
  input  wire logic [psc_pkg::WORD_W-1:0]    wr_data_in
);
  import psc_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] rdata;
  } psc_array_state_type;

  psc_array_state_type state_reg;
  psc_array_state_type state_next;

  // storage, contents undefined after power-up
  logic [WORD_W-1:0] mem [DEPTH];

  // read register only moves on a read
  always_comb begin
    state_next = state_reg;
    if (rd_en_in) begin
      state_next.rdata = mem[rd_addr_in];
      // a write landing at the same edge is seen by the read
      if (wr_addr_in == rd_addr_in) begin
        for (int i = 0; i < LANES; i++) begin
          if (wr_lanes_in[i]) begin
            state_next.rdata[i*LANE_W +: LANE_W] = wr_data_in[i*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    state_reg <= state_next;
  end

  // per-lane write, other lanes keep their bytes
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_lanes_in[i]) begin
        mem[wr_addr_in][i*LANE_W +: LANE_W] <= wr_data_in[i*LANE_W +: LANE_W];
      end
    end
  end

  assign rd_data_out = state_reg.rdata;

endmodule : psc_array

// ### hdl/psc_cycle_decode.sv
`timescale 1ns/10ps

// Function
// - selected, load low, write select high: load address, start read burst
// - load high after read start: next burst address, selects and write ignored
// - read with output gate inactive still accesses, data bus stays floating
// - read continuation with gate inactive advances address, bus stays undriven
// - selected, load and write low, a lane low: load address, start write
// - load high in write burst, lane low: write next burst address
// - write start with no lane selected is aborted, nothing stored
// - write continuation with no lane advances address, stores nothing
// - clock qualifier high: edge ignored, address and pipeline held
// - after power-up device is deselected, data and parity floating
// - output gate is a combinational driver enable, never sampled
// - write data phase forces data and parity drivers off
// - read data driven only with gate active and the burst loaded while selected
// - each lane select writes its byte plus parity bit, others kept
// - a write stores data only when some lane select is low
// - sleep overrides all inputs, floats outputs, two cycles in or out
// - burst order low linear, high interleaved, four beats wrapping
module psc_cycle_decode
  import psc_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  // control inputs, sampled at the rising edge
  input  wire logic                          clock_qualifier_n_in,
  input  wire logic                          chip_select1_n_in,
  input  wire logic                          chip_select2_in,
  input  wire logic                          chip_select3_n_in,
  input  wire logic                          advance_or_load_in,
  input  wire logic                          write_select_n_in,
  input  wire logic [psc_pkg::LANES-1:0]     byte_lane_select_n_in,
  input  wire logic                          burst_order_in,
  input  wire logic [psc_pkg::ADDR_W-1:0]    addr_in,
  // asynchronous controls
  input  wire logic                          output_gate_n_in,
  input  wire logic                          sleep_request_in,
  // data and parity pins, split into three signals
  input  wire logic [psc_pkg::DATA_W-1:0]    data_in,
  output logic      [psc_pkg::DATA_W-1:0]    data_out,
  output logic                               data_oe_out,
  input  wire logic [psc_pkg::LANES-1:0]     parity_io_in,
  output logic      [psc_pkg::LANES-1:0]     parity_io_out,
  output logic                               parity_io_oe_out,
  // status
  output logic                               sleep_active_out
);
  import psc_pkg::*;

  typedef struct packed {
    // burst in progress
    psc_op_type              burst_op;
    logic                    burst_interleaved;
    logic [HI_W-1:0]         burst_hi;
    logic [BURST_W-1:0]      burst_start;
    logic [BURST_W-1:0]      burst_beat;
    // first stage: address and lanes of the access under way
    psc_op_type              s1_op;
    logic [ADDR_W-1:0]       s1_addr;
    logic [LANES-1:0]        s1_lanes;
    // second stage: data phase on the pins
    psc_op_type              s2_op;
    logic [ADDR_W-1:0]       s2_addr;
    logic [LANES-1:0]        s2_lanes;
    // sleep sequencing
    psc_sleep_type           sleep_state;
    logic [SLEEP_CNT_W-1:0]  sleep_cnt;
  } psc_state_type;

  psc_state_type state_reg;
  psc_state_type state_next;

  // combined decode terms
  logic                      selected;
  logic                      awake;
  logic                      edge_taken;
  logic                      read_drive;
  logic                      write_due;
  logic                      mem_rd_en;
  logic [LANES-1:0]          mem_wr_lanes;
  logic [WORD_W-1:0]         mem_rd_data;
  logic [WORD_W-1:0]         mem_wr_data;

  // low address bits of a burst beat
  function automatic logic [BURST_W-1:0] burst_low(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] beat,
    input logic               interleaved
  );
    logic [BURST_W-1:0] low;
    low = start + beat;
    if (interleaved) begin
      low = start ^ beat;
    end
    return low;
  endfunction : burst_low

  // pack data and parity into lane-ordered words
  function automatic logic [WORD_W-1:0] pack_word(
    input logic [DATA_W-1:0] data,
    input logic [LANES-1:0]  parity
  );
    logic [WORD_W-1:0] word;
    word = '0;
    for (int i = 0; i < LANES; i++) begin
      word[i*LANE_W +: LANE_W] = {parity[i], data[i*BYTE_W +: BYTE_W]};
    end
    return word;
  endfunction : pack_word

  // all three chip selects active
  assign selected = !chip_select1_n_in && chip_select2_in && !chip_select3_n_in;

  // sleep overrides everything from the moment it is requested
  assign awake = (state_reg.sleep_state == PSC_SLP_AWAKE) && !sleep_request_in;

  // an edge counts only when awake and qualified
  assign edge_taken = awake && !clock_qualifier_n_in;

  // next-state logic
  always_comb begin
    state_next = state_reg;

    case (state_reg.sleep_state)
      PSC_SLP_AWAKE: begin
        if (sleep_request_in) begin
          // the request edge is the first of the two cycles
          state_next.sleep_state = PSC_SLP_ENTER;
          state_next.sleep_cnt   = 2'h1;
        end
      end
      PSC_SLP_ENTER: begin
        if (!sleep_request_in) begin
          // the drop edge is the first of the two wake cycles
          state_next.sleep_state = PSC_SLP_WAKE;
          state_next.sleep_cnt   = 2'h1;
        end else if (state_reg.sleep_cnt == SLEEP_LAST) begin
          state_next.sleep_state = PSC_SLP_ASLEEP;
        end else begin
          state_next.sleep_cnt = state_reg.sleep_cnt + 2'h1;
        end
      end
      PSC_SLP_ASLEEP: begin
        if (!sleep_request_in) begin
          // the drop edge is the first of the two wake cycles
          state_next.sleep_state = PSC_SLP_WAKE;
          state_next.sleep_cnt   = 2'h1;
        end
      end
      PSC_SLP_WAKE: begin
        if (sleep_request_in) begin
          // sleep again during wake restarts the entry count
          state_next.sleep_state = PSC_SLP_ENTER;
          state_next.sleep_cnt   = 2'h1;
        end else if (state_reg.sleep_cnt == SLEEP_LAST) begin
          state_next.sleep_state = PSC_SLP_AWAKE;
        end else begin
          state_next.sleep_cnt = state_reg.sleep_cnt + 2'h1;
        end
      end
      default: begin
        state_next.sleep_state = PSC_SLP_AWAKE;
        state_next.sleep_cnt   = '0;
      end
    endcase

    if (!awake) begin
      state_next.burst_op = PSC_OP_NONE;
      state_next.s1_op    = PSC_OP_NONE;
      state_next.s2_op    = PSC_OP_NONE;
      state_next.s2_lanes = LANES_OFF;
    end else if (edge_taken) begin
      // data phase follows the first stage
      state_next.s2_op    = state_reg.s1_op;
      state_next.s2_addr  = state_reg.s1_addr;
      state_next.s2_lanes = state_reg.s1_lanes;

      if (!advance_or_load_in) begin
        if (!selected) begin
          state_next.burst_op = PSC_OP_NONE;
          state_next.s1_op    = PSC_OP_NONE;
          state_next.s1_lanes = LANES_OFF;
        end else if (write_select_n_in) begin
          state_next.burst_op          = PSC_OP_READ;
          state_next.burst_interleaved = burst_order_in;
          state_next.burst_hi          = addr_in[ADDR_W-1:BURST_W];
          state_next.burst_start       = addr_in[BURST_W-1:0];
          state_next.burst_beat        = BEAT_RESET;
          state_next.s1_op             = PSC_OP_READ;
          state_next.s1_addr           = addr_in;
          state_next.s1_lanes          = LANES_OFF;
        end else if (byte_lane_select_n_in != LANES_NONE) begin
          state_next.burst_op          = PSC_OP_WRITE;
          state_next.burst_interleaved = burst_order_in;
          state_next.burst_hi          = addr_in[ADDR_W-1:BURST_W];
          state_next.burst_start       = addr_in[BURST_W-1:0];
          state_next.burst_beat        = BEAT_RESET;
          state_next.s1_op             = PSC_OP_WRITE;
          state_next.s1_addr           = addr_in;
          state_next.s1_lanes          = ~byte_lane_select_n_in;
        end else begin
          state_next.burst_op = PSC_OP_NONE;
          state_next.s1_op    = PSC_OP_WRITE;
          state_next.s1_lanes = LANES_OFF;
        end
      end else if (state_reg.burst_op == PSC_OP_NONE) begin
        state_next.s1_op    = PSC_OP_NONE;
        state_next.s1_lanes = LANES_OFF;
      end else begin
        // continuation ignores selects and write select
        // next beat, linear or interleaved, wrapping
        state_next.burst_beat = state_reg.burst_beat + 2'h1;
        state_next.s1_op      = state_reg.burst_op;
        state_next.s1_addr    = {state_reg.burst_hi,
                                 burst_low(state_reg.burst_start,
                                           state_reg.burst_beat + 2'h1,
                                           state_reg.burst_interleaved)};
        state_next.s1_lanes   = LANES_OFF;
        if (state_reg.burst_op == PSC_OP_WRITE) begin
          // lanes of this beat, none means no store
          state_next.s1_lanes = ~byte_lane_select_n_in;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg.burst_op          <= PSC_OP_NONE;
      state_reg.burst_interleaved <= 1'b0;
      state_reg.burst_hi          <= '0;
      state_reg.burst_start       <= BEAT_RESET;
      state_reg.burst_beat        <= BEAT_RESET;
      state_reg.s1_op             <= PSC_OP_NONE;
      state_reg.s1_addr           <= ADDR_RESET;
      state_reg.s1_lanes          <= LANES_OFF;
      state_reg.s2_op             <= PSC_OP_NONE;
      state_reg.s2_addr           <= ADDR_RESET;
      state_reg.s2_lanes          <= LANES_OFF;
      state_reg.sleep_state       <= PSC_SLP_AWAKE;
      state_reg.sleep_cnt         <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // array read happens whatever the gate level
  assign mem_rd_en = edge_taken && (state_reg.s1_op == PSC_OP_READ);

  // write data captured at the second edge after the command
  // once the write has moved into the second stage
  assign write_due = edge_taken && (state_reg.s2_op == PSC_OP_WRITE);

  // store only with some lane selected
  assign mem_wr_lanes = write_due ? state_reg.s2_lanes : LANES_OFF;
  assign mem_wr_data  = pack_word(data_in, parity_io_in);

  // array read from the first stage, write from the second
  psc_array u_array (
    .clk_in      (clk_in),
    .rd_en_in    (mem_rd_en),
    .rd_addr_in  (state_reg.s1_addr),
    .rd_data_out (mem_rd_data),
    .wr_lanes_in (mem_wr_lanes),
    .wr_addr_in  (state_reg.s2_addr),
    .wr_data_in  (mem_wr_data)
  );

  // the data slot of a read is the cycle after its array read
  // gate acts only combinationally on read data phase
  assign read_drive = (state_reg.s2_op == PSC_OP_READ) && awake && !output_gate_n_in;

  // unpack read word onto data and parity pins
  always_comb begin
    data_out      = '0;
    parity_io_out = '0;
    for (int i = 0; i < LANES; i++) begin
      data_out[i*BYTE_W +: BYTE_W] = mem_rd_data[i*LANE_W +: BYTE_W];
      parity_io_out[i]             = mem_rd_data[i*LANE_W + BYTE_W];
    end
  end

  // driver enables
  assign data_oe_out      = read_drive;
  assign parity_io_oe_out = read_drive;
  assign sleep_active_out = (state_reg.sleep_state == PSC_SLP_ASLEEP);

endmodule : psc_cycle_decode

// ### tb/psc_checker.sv
`timescale 1ns/10ps

module psc_checker (
  // clock and reset
  input wire logic                        clk_in,
  input wire logic                        rst_in,
  // controls
  input wire logic                        clock_qualifier_n_in,
  input wire logic                        chip_select1_n_in,
  input wire logic                        chip_select2_in,
  input wire logic                        chip_select3_n_in,
  input wire logic                        advance_or_load_in,
  input wire logic                        write_select_n_in,
  input wire logic                        output_gate_n_in,
  input wire logic                        sleep_request_in,
  // outputs watched
  input wire logic [psc_pkg::DATA_W-1:0]  data_out,
  input wire logic                        data_oe_out,
  input wire logic                        parity_io_oe_out,
  input wire logic                        sleep_active_out
);
  import psc_pkg::*;
  logic sel;
  logic go;
  logic ld_rd;
  logic ld_wr;
  // qualified edge and load decode
  assign sel   = !chip_select1_n_in && chip_select2_in && !chip_select3_n_in;
  assign go    = !clock_qualifier_n_in && !sleep_request_in && !sleep_active_out;
  assign ld_rd = go && sel && !advance_or_load_in && write_select_n_in;
  assign ld_wr = go && sel && !advance_or_load_in && !write_select_n_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // read taken, then one qualified edge into the data slot
  sequence s_read;
    ld_rd ##1 go;
  endsequence
  // deselect taken, then one qualified edge into its slot
  sequence s_desel;
    go && !sel && !advance_or_load_in ##1 go;
  endsequence
  AST_RESET: assert property ($fell(rst_in) |-> !data_oe_out && !sleep_active_out)
    else $error("outputs active after reset");
  AST_READ: assert property (s_read ##1 (!output_gate_n_in && !sleep_request_in) |-> data_oe_out)
    else $error("read slot not driven");
  AST_WRITE: assert property (ld_wr ##1 go |=> !data_oe_out)
    else $error("driver on in write data phase");
  AST_GATE: assert property (output_gate_n_in |-> !data_oe_out)
    else $error("driving with gate inactive");
  AST_PAIR: assert property (data_oe_out == parity_io_oe_out)
    else $error("data and parity enables differ");
  AST_DESEL: assert property (s_desel |=> !data_oe_out)
    else $error("driving after deselect");
  AST_SLEEP: assert property (sleep_request_in |-> !data_oe_out && !parity_io_oe_out)
    else $error("driving while sleep requested");
  AST_ASLEEP: assert property (sleep_request_in ##1 sleep_request_in |=> sleep_active_out)
    else $error("sleep not reached in two cycles");
  AST_STALL: assert property (clock_qualifier_n_in && !sleep_request_in |=> $stable(data_out))
    else $error("data changed on ignored edge");
endmodule : psc_checker

bind psc_cycle_decode psc_checker chk_i (
  .clk_in, .rst_in, .clock_qualifier_n_in, .chip_select1_n_in, .chip_select2_in,
  .chip_select3_n_in, .advance_or_load_in, .write_select_n_in, .output_gate_n_in,
  .sleep_request_in, .data_out, .data_oe_out, .parity_io_oe_out, .sleep_active_out
);

// ### tb/psc_master.sv
`timescale 1ns/10ps

module psc_master (
  // clock
  input  wire logic                        clk_in,
  // write beat request
  input  wire logic                        wr_in,
  input  wire logic [psc_pkg::DATA_W-1:0]  d_in,
  input  wire logic [psc_pkg::LANES-1:0]   p_in,
  // pin values seen by the device
  output logic      [psc_pkg::DATA_W-1:0]  d_out,
  output logic      [psc_pkg::LANES-1:0]   p_out
);
  import psc_pkg::*;
  logic [1:0]        v_reg = 2'h0;
  logic [WORD_W-1:0] s1_reg;
  logic [WORD_W-1:0] s2_reg;
  always @(posedge clk_in) begin
    v_reg  <= {v_reg[0], wr_in};
    s1_reg <= {p_in, d_in};
    s2_reg <= s1_reg;
  end
  // released bus shows inverse pattern
  assign {p_out, d_out} = v_reg[1] ? s2_reg : ~s2_reg;
endmodule : psc_master

// ### tb/psc_cycle_decode_bench.sv
`timescale 1ns/10ps

module psc_cycle_decode_bench;
  import psc_pkg::*;
  typedef struct packed {
    logic [3:0] ln; logic [16:0] a; logic [31:0] d; logic [35:0] e;
  } psc_row_type;
  // rows: lanes, address, data, word expected on read-back
  psc_row_type rows [6] = '{
    '{4'h0, 17'h00010, 32'h11223344, 36'h111223344},
    '{4'hE, 17'h00010, 32'hAABBCCDD, 36'h0112233DD},
    '{4'h5, 17'h00010, 32'h55667788, 36'h0552277DD},
    '{4'hF, 17'h00010, 32'hDEADBEEF, 36'h0552277DD},
    '{4'h0, 17'h1FFFF, 32'h01234567, 36'h001234567},
    '{4'hA, 17'h1FFFF, 32'h89ABCDEF, 36'h001AB45EF}};
  logic clk_in = 1'b0, rst_in = 1'b1, clock_qualifier_n_in = 1'b0, advance_or_load_in = 1'b0;
  logic chip_select1_n_in = 1'b1, chip_select2_in = 1'b1, chip_select3_n_in = 1'b0;
  logic write_select_n_in = 1'b1, burst_order_in = 1'b0, output_gate_n_in = 1'b0;
  logic sleep_request_in = 1'b0, data_oe_out, parity_io_oe_out, sleep_active_out;
  logic w_v = 1'b0, r_v = 1'b0;
  logic [1:0]        p_v = 2'h0;
  logic [3:0]        byte_lane_select_n_in = LANES_NONE, parity_io_in, parity_io_out;
  logic [16:0]       addr_in = ADDR_RESET;
  logic [31:0]       data_in, data_out, w_d = 32'h0;
  logic [WORD_W-1:0] e_w = '0, e0, e1;
  logic [WORD_W-1:0] mem [int];
  int err_count = 0, comparisons = 0;

  always #25 clk_in = ~clk_in;

  psc_cycle_decode dut (
    .clk_in, .rst_in, .clock_qualifier_n_in, .chip_select1_n_in, .chip_select2_in,
    .chip_select3_n_in, .advance_or_load_in, .write_select_n_in, .byte_lane_select_n_in,
    .burst_order_in, .addr_in, .output_gate_n_in, .sleep_request_in, .data_in, .data_out,
    .data_oe_out, .parity_io_in, .parity_io_out, .parity_io_oe_out, .sleep_active_out);
  psc_master bus (.clk_in, .wr_in(w_v), .d_in(w_d), .p_in(w_d[31:28]), .d_out(data_in),
    .p_out(parity_io_in));

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // one cycle: k 0 read, 1 write, 2 deselect; ld loads, else continues
  task automatic op(input int k, input logic ld, input logic [3:0] ln,
                    input logic [16:0] a, input logic [31:0] d);
    logic [35:0] m;
    m = {~ln, {8{~ln[3]}}, {8{~ln[2]}}, {8{~ln[1]}}, {8{~ln[0]}}};
    @(posedge clk_in);
    // chip select 1 made inactive and write select flipped on continuation
    advance_or_load_in    <= !ld;
    chip_select1_n_in     <= !(ld && k < 2);
    chip_select2_in       <= (k != 2);
    write_select_n_in     <= (k != 1) == ld;
    byte_lane_select_n_in <= ln;
    addr_in               <= ld ? a : ~a;
    w_v                   <= (k == 1);
    w_d                   <= d;
    r_v                   <= (k == 0);
    if (!mem.exists(int'(a))) mem[a] = '0;
    if (k == 1) mem[a] = (mem[a] & ~m) | ({d[31:28], d} & m);
    if (k == 0) e_w <= mem[a];
  endtask : op

  task automatic idle(input int n);
    op(2, 1'b1, 4'hF, 17'h0, 32'h0);
    repeat (n - 1) op(2, 1'b0, 4'hF, 17'h0, 32'h0);
  endtask : idle

  // read slot monitor, the cycle after the next qualified edge
  always @(posedge clk_in) begin
    if (sleep_request_in) p_v <= 2'h0;
    else if (!clock_qualifier_n_in) begin
      p_v <= {p_v[0], r_v};
      e0  <= e_w;
      e1  <= e0;
    end
  end
  always @(negedge clk_in) begin
    if (p_v[1]) begin
      chk(36'(data_oe_out), 36'(!output_gate_n_in && !sleep_request_in));
      if (!output_gate_n_in && !sleep_request_in) chk({parity_io_out, data_out}, e1);
    end
  end

  initial begin
    #50000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk(36'({data_oe_out, parity_io_oe_out, sleep_active_out}), 36'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      op(1, 1'b1, rows[i].ln, rows[i].a, rows[i].d);
      mem[rows[i].a] = rows[i].e;
      op(0, 1'b1, 4'hF, rows[i].a, 32'h0);
      idle(1);
    end
    idle(4);
    $display("test rows done");
    // linear write bursts wrap, interleaved read burst
    for (int b = 0; b < 4; b++) op(1, b == 0, 4'h0, {15'h0800, 2'(3 + b)}, {8'(b), 24'h5A5A5A});
    for (int b = 0; b < 4; b++)
      op(1, b == 0, b == 2 ? 4'hF : 4'hF ^ 4'(1 << b), {15'h0800, 2'(1 + b)}, 32'hC3C3C3C3);
    idle(1);
    burst_order_in <= 1'b1;
    for (int b = 0; b < 4; b++) op(0, b == 0, 4'hF, {15'h0800, 2'h2 ^ 2'(b)}, 32'h0);
    burst_order_in <= 1'b0;
    idle(4);
    $display("test burst done");
    op(0, 1'b1, 4'hF, 17'h00010, 32'h0);
    output_gate_n_in <= 1'b1;
    idle(4);
    output_gate_n_in <= 1'b0;
    $display("test dummy read done");
    op(0, 1'b1, 4'hF, 17'h00010, 32'h0);
    op(2, 1'b1, 4'hF, 17'h0, 32'h0);
    clock_qualifier_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    clock_qualifier_n_in <= 1'b0;
    idle(5);
    $display("test stall done");
    @(posedge clk_in);
    sleep_request_in <= 1'b1;
    @(negedge clk_in);
    chk(36'(data_oe_out), 36'h0);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk(36'(sleep_active_out), 36'h1);
    @(posedge clk_in);
    sleep_request_in <= 1'b0;
    idle(4);
    op(0, 1'b1, 4'hF, 17'h1FFFF, 32'h0);
    idle(4);
    $display("test sleep done");
    finish_test();
  end
endmodule : psc_cycle_decode_bench
